// [hdl/dmsr_consts.svh]
// offsets, field positions and timing constants of the drive monitor register bank
`ifndef DMSR_CONSTS_SVH
`define DMSR_CONSTS_SVH
`define DMSR_ADDR_W 16
`define DMSR_DATA_W 16
`define DMSR_OFF_INPUTS 16'h002b
`define DMSR_OFF_STATUS 16'h002c
`define DMSR_OFF_OUTPUTS 16'h002d
`define DMSR_OFF_DC_BUS 16'h0031
`define DMSR_OFF_LOOP_FB 16'h0038
`define DMSR_OFF_LOOP_IN 16'h0039
`define DMSR_OFF_LOOP_OUT 16'h003a
`define DMSR_OFF_CPU_SW 16'h003b
`define DMSR_OFF_FLASH_SW 16'h003c
`define DMSR_OFF_LINK_ERR 16'h003d
`define DMSR_OFF_CAPACITY 16'h003e
`define DMSR_OFF_CTRL_METHOD 16'h003f
`define DMSR_RANGE_LO 16'h002b
`define DMSR_RANGE_HI 16'h003f
`define DMSR_INPUT_COUNT 7
`define DMSR_OUTPUT_COUNT 2
`define DMSR_LINK_ERR_COUNT 7
`define DMSR_LINK_ERR_MASK 7'h7b
`define DMSR_ST_RUN 0
`define DMSR_ST_ZERO_SPEED 1
`define DMSR_ST_FREQ_AGREE 2
`define DMSR_ST_DESIRED_AGREE 3
`define DMSR_ST_FREQ_LE 4
`define DMSR_ST_FREQ_GE 5
`define DMSR_ST_STARTUP_DONE 6
`define DMSR_ST_LOW_VOLTAGE 7
`define DMSR_ST_REF_SRC 9
`define DMSR_ST_RUN_SRC 10
`define DMSR_ST_OVERTORQUE 11
`define DMSR_ST_REF_LOST 12
`define DMSR_ST_RETRY 13
`define DMSR_ST_ERROR 14
`define DMSR_ST_LINK_TIMEOUT 15
`define DMSR_ERR_TIMEOUT_BIT 6
`define DMSR_SAMPLE_NS 1000
`define DMSR_CLK_NS 25
`define DMSR_SAMPLE_CYCLES (`DMSR_SAMPLE_NS / `DMSR_CLK_NS)
`endif

// [hdl/dmsr_pkg.sv]
// types shared by the drive monitor register bank
`default_nettype none
package dmsr_pkg;
	typedef struct packed {
		logic run;
		logic zero_speed;
		logic freq_agree;
		logic desired_agree;
		logic startup_done;
		logic low_voltage;
		logic ref_from_other;
		logic run_from_other;
		logic overtorque;
		logic ref_lost;
		logic retrying;
		logic fault;
	} dmsr_drive_flags_s;
	typedef struct packed {
		logic [15:0] dc_bus;
		logic [15:0] loop_fb;
		logic [15:0] loop_in;
		logic [15:0] loop_out;
		logic [15:0] out_freq;
		logic [15:0] detect_level;
	} dmsr_levels_s;
	typedef struct packed {
		logic [15:0] cpu_sw;
		logic [15:0] flash_sw;
		logic [15:0] capacity;
		logic [15:0] ctrl_method;
	} dmsr_ident_s;
	typedef enum logic [1:0] {
		DMSR_IDLE = 2'b01,
		DMSR_ANSWER = 2'b10
	} dmsr_read_e;
endpackage
`default_nettype wire

// [hdl/dmsr_err_latch.sv]
// sticky communication error flags, held until a fault reset
`timescale 1ns/1ps
`default_nettype none
module dmsr_err_latch #(
	parameter int WIDTH = 7
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_reset_n,
	// events and clear
	input wire logic [WIDTH-1:0] i_set,
	input wire logic i_clear,
	// held flags
	output logic [WIDTH-1:0] o_flags
);
	logic [WIDTH-1:0] flags_ff;
	logic [WIDTH-1:0] nxt_flags;
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++)
		begin : g_bit
			// set beats clear so an event in the clear cycle survives
			always_comb
			begin
				nxt_flags[g] = i_set[g] | (flags_ff[g] & ~i_clear);
			end
		end
	endgenerate
	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			flags_ff <= '0;
		else
			flags_ff <= nxt_flags;
	end
	assign o_flags = flags_ff;
endmodule // dmsr_err_latch
`default_nettype wire

// [hdl/dmsr_monitor_regs.sv]
// read-only monitor register bank of the motor drive
//
// What this block does
// - input status word bits 0..6 show terminals one..seven, 1 on; rest zero.
// - status bits 0..3: operating, zero speed, frequency agree, desired agree.
// - bit 4 when output frequency <= detection level, bit 5 when >=.
// - bit 6 startup completed, bit 7 low voltage detected.
// - bit 9 reference source, bit A run source; 0 communication, 1 other.
// - bit B overtorque, bit C reference lost, bit D retrying error.
// - bit E set on a drive fault or a link time-out; other link errors leave it clear.
// - bit F set on link time-out.
// - output word bit 0 contact one, bit 1 contact two, 1 on.
// - DC bus voltage readable as a monitor word.
// - loop feedback unsigned, ten counts per percent.
// - loop input and output signed, ten counts per percent.
// - link error flags latch until fault reset, accepted while operating.
// - monitor registers are read-only; writes change nothing.
`timescale 1ns/1ps
`default_nettype none
`include "dmsr_consts.svh"
module dmsr_monitor_regs #(
	parameter int SAMPLE_CYCLES = `DMSR_SAMPLE_CYCLES
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_reset_n,
	// drive state
	input wire logic [`DMSR_INPUT_COUNT-1:0] i_input_terminals,
	input wire logic [`DMSR_OUTPUT_COUNT-1:0] i_output_contacts,
	input wire dmsr_pkg::dmsr_drive_flags_s i_flags,
	input wire dmsr_pkg::dmsr_levels_s i_levels,
	input wire dmsr_pkg::dmsr_ident_s i_ident,
	// link error events and fault reset
	input wire logic [`DMSR_LINK_ERR_COUNT-1:0] i_link_err,
	input wire logic i_fault_reset,
	// register port from the serial slave
	input wire logic i_rd,
	input wire logic i_wr,
	input wire logic [`DMSR_ADDR_W-1:0] i_addr,
	output logic o_ack,
	output logic o_hit,
	output logic [`DMSR_DATA_W-1:0] o_rdata
);
	////////////////////////////////////////////////////////////////////////
	// sampling tick
	logic [15:0] tick_cnt_ff;
	logic [15:0] nxt_tick_cnt;
	logic tick;
	always_comb
	begin
		tick = (tick_cnt_ff == 16'(SAMPLE_CYCLES - 1));
		nxt_tick_cnt = tick ? 16'h0000 : tick_cnt_ff + 16'h0001;
	end
	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			tick_cnt_ff <= 16'h0000;
		else
			tick_cnt_ff <= nxt_tick_cnt;
	end

	////////////////////////////////////////////////////////////////////////
	// error latch
	logic [`DMSR_LINK_ERR_COUNT-1:0] err_flags;
	dmsr_err_latch #(
		.WIDTH(`DMSR_LINK_ERR_COUNT)
	) u_err (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_set(i_link_err & 7'(`DMSR_LINK_ERR_MASK)),
		.i_clear(i_fault_reset),
		.o_flags(err_flags)
	);

	////////////////////////////////////////////////////////////////////////
	// sampled snapshot; reads see a coherent set taken on each tick
	logic [15:0] inputs_ff, status_ff, outputs_ff, dc_ff, fb_ff, in_ff, out_ff;
	logic [15:0] nxt_inputs, nxt_status, nxt_outputs, nxt_dc, nxt_fb, nxt_in, nxt_out;
	logic timeout;
	always_comb
	begin
		timeout = err_flags[`DMSR_ERR_TIMEOUT_BIT];
		nxt_inputs = inputs_ff;
		nxt_status = status_ff;
		nxt_outputs = outputs_ff;
		nxt_dc = dc_ff;
		nxt_fb = fb_ff;
		nxt_in = in_ff;
		nxt_out = out_ff;
		if (tick)
		begin
			nxt_inputs = {9'h000, i_input_terminals};
			nxt_status = 16'h0000;
			nxt_status[`DMSR_ST_RUN] = i_flags.run;
			nxt_status[`DMSR_ST_ZERO_SPEED] = i_flags.zero_speed;
			nxt_status[`DMSR_ST_FREQ_AGREE] = i_flags.freq_agree;
			nxt_status[`DMSR_ST_DESIRED_AGREE] = i_flags.desired_agree;
			nxt_status[`DMSR_ST_FREQ_LE] =
				(i_levels.out_freq <= i_levels.detect_level);
			nxt_status[`DMSR_ST_FREQ_GE] =
				(i_levels.out_freq >= i_levels.detect_level);
			nxt_status[`DMSR_ST_STARTUP_DONE] = i_flags.startup_done;
			nxt_status[`DMSR_ST_LOW_VOLTAGE] = i_flags.low_voltage;
			nxt_status[`DMSR_ST_REF_SRC] = i_flags.ref_from_other;
			nxt_status[`DMSR_ST_RUN_SRC] = i_flags.run_from_other;
			nxt_status[`DMSR_ST_OVERTORQUE] = i_flags.overtorque;
			nxt_status[`DMSR_ST_REF_LOST] = i_flags.ref_lost;
			nxt_status[`DMSR_ST_RETRY] = i_flags.retrying;
			nxt_status[`DMSR_ST_ERROR] = i_flags.fault | timeout;
			nxt_status[`DMSR_ST_LINK_TIMEOUT] = timeout;
			nxt_outputs = {14'h0000, i_output_contacts};
			nxt_dc = i_levels.dc_bus;
			nxt_fb = i_levels.loop_fb;
			nxt_in = i_levels.loop_in;
			nxt_out = i_levels.loop_out;
		end
	end
	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			inputs_ff <= 16'h0000;
			status_ff <= 16'h0000;
			outputs_ff <= 16'h0000;
			dc_ff <= 16'h0000;
			fb_ff <= 16'h0000;
			in_ff <= 16'h0000;
			out_ff <= 16'h0000;
		end
		else
		begin
			inputs_ff <= nxt_inputs;
			status_ff <= nxt_status;
			outputs_ff <= nxt_outputs;
			dc_ff <= nxt_dc;
			fb_ff <= nxt_fb;
			in_ff <= nxt_in;
			out_ff <= nxt_out;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read port: one-cycle answer, writes acknowledged but ignored
	dmsr_pkg::dmsr_read_e state_ff, nxt_state;
	logic [15:0] rdata_ff, nxt_rdata;
	logic hit_ff, nxt_hit;
	logic in_range;
	always_comb
	begin
		in_range = (i_addr >= `DMSR_RANGE_LO) && (i_addr <= `DMSR_RANGE_HI);
		nxt_state = dmsr_pkg::DMSR_IDLE;
		nxt_rdata = rdata_ff;
		nxt_hit = hit_ff;
		unique case (state_ff)
			dmsr_pkg::DMSR_IDLE:
			begin
				if (i_rd || i_wr)
				begin
					nxt_state = dmsr_pkg::DMSR_ANSWER;
					nxt_hit = in_range;
					nxt_rdata = 16'h0000;
					if (i_rd)
					begin
						unique case (i_addr)
							`DMSR_OFF_INPUTS: nxt_rdata = inputs_ff;
							`DMSR_OFF_STATUS: nxt_rdata = status_ff;
							`DMSR_OFF_OUTPUTS: nxt_rdata = outputs_ff;
							`DMSR_OFF_DC_BUS: nxt_rdata = dc_ff;
							`DMSR_OFF_LOOP_FB: nxt_rdata = fb_ff;
							`DMSR_OFF_LOOP_IN: nxt_rdata = in_ff;
							`DMSR_OFF_LOOP_OUT: nxt_rdata = out_ff;
							`DMSR_OFF_CPU_SW: nxt_rdata = i_ident.cpu_sw;
							`DMSR_OFF_FLASH_SW: nxt_rdata = i_ident.flash_sw;
							`DMSR_OFF_LINK_ERR: nxt_rdata = {9'h000, err_flags};
							`DMSR_OFF_CAPACITY: nxt_rdata = i_ident.capacity;
							`DMSR_OFF_CTRL_METHOD: nxt_rdata = i_ident.ctrl_method;
							default: nxt_rdata = 16'h0000;
						endcase
					end
					// a write stores nothing
				end
			end
			dmsr_pkg::DMSR_ANSWER:
				nxt_state = dmsr_pkg::DMSR_IDLE;
			default:
				nxt_state = dmsr_pkg::DMSR_IDLE;
		endcase
	end
	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			state_ff <= dmsr_pkg::DMSR_IDLE;
			rdata_ff <= 16'h0000;
			hit_ff <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			rdata_ff <= nxt_rdata;
			hit_ff <= nxt_hit;
		end
	end
	assign o_ack = (state_ff == dmsr_pkg::DMSR_ANSWER);
	assign o_hit = hit_ff;
	assign o_rdata = rdata_ff;
endmodule // dmsr_monitor_regs
`default_nettype wire

// [verification/dmsr_monitor_regs_chk.sv]
// assertions on the register port of the drive monitor bank
`timescale 1ns/1ps
`default_nettype none
`include "dmsr_consts.svh"
module dmsr_monitor_regs_chk #(
	parameter int SAMPLE_CYCLES = 2
) (
	// watched ports
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic [`DMSR_INPUT_COUNT-1:0] i_input_terminals,
	input wire logic [`DMSR_OUTPUT_COUNT-1:0] i_output_contacts,
	input wire dmsr_pkg::dmsr_drive_flags_s i_flags,
	input wire dmsr_pkg::dmsr_levels_s i_levels,
	input wire dmsr_pkg::dmsr_ident_s i_ident,
	input wire logic [`DMSR_LINK_ERR_COUNT-1:0] i_link_err,
	input wire logic i_fault_reset,
	input wire logic i_rd,
	input wire logic i_wr,
	input wire logic [`DMSR_ADDR_W-1:0] i_addr,
	input wire logic o_ack,
	input wire logic o_hit,
	input wire logic [`DMSR_DATA_W-1:0] o_rdata
);
default clocking dc @(posedge i_clk);
endclocking
default disable iff (!i_reset_n);
////////////////////////////////////////////////////////////////////////////////
ack_answer_a: assert property ((i_rd || i_wr) && !o_ack |=> o_ack)
	else $error("request not answered");
ack_single_a: assert property (o_ack |=> !o_ack)
	else $error("ack longer than one cycle");
write_zero_a: assert property (o_ack && $past(i_wr) |-> o_rdata == 16'h0000)
	else $error("write returned data");
hit_range_a: assert property (o_ack |-> o_hit == ($past(i_addr) inside {[16'h002b:16'h003f]}))
	else $error("hit wrong");
hole_zero_a: assert property (o_ack && $past(i_addr) inside {[16'h002e:16'h0030], [16'h0032:16'h0037]}
	|-> o_rdata == 16'h0000)
	else $error("unused address not zero");
input_bits_a: assert property (o_ack && $past(i_rd && i_addr == 16'h002b) |-> o_rdata[15:7] == 9'h000)
	else $error("input word upper bits set");
contact_bits_a: assert property (o_ack && $past(i_rd && i_addr == 16'h002d) |-> o_rdata[15:2] == 14'h0000)
	else $error("output word upper bits set");
error_bits_a: assert property (o_ack && $past(i_rd && i_addr == 16'h003d)
	|-> o_rdata[15:7] == 9'h000 && !o_rdata[2])
	else $error("error word unused bits set");
cover property (o_ack && o_hit);
cover property (o_ack && !o_hit);
cover property (i_fault_reset && i_flags.run);
cover property (i_fault_reset && i_link_err != 7'h00);
endmodule // dmsr_monitor_regs_chk
bind dmsr_monitor_regs dmsr_monitor_regs_chk #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) u_chk (
	.i_clk(i_clk), .i_reset_n(i_reset_n), .i_input_terminals(i_input_terminals),
	.i_output_contacts(i_output_contacts), .i_flags(i_flags), .i_levels(i_levels),
	.i_ident(i_ident), .i_link_err(i_link_err), .i_fault_reset(i_fault_reset),
	.i_rd(i_rd), .i_wr(i_wr), .i_addr(i_addr), .o_ack(o_ack), .o_hit(o_hit), .o_rdata(o_rdata)
);
`default_nettype wire

// [verification/dmsr_master_model.sv]
// register-port master standing in for the serial controller
`timescale 1ns/1ps
`default_nettype none
module dmsr_master_model (
	// clock
	input wire logic i_clk,
	// request
	output logic o_rd,
	output logic o_wr,
	output logic [15:0] o_addr,
	// answer
	input wire logic i_ack,
	input wire logic i_hit,
	input wire logic [15:0] i_rdata
);
initial
begin
	o_rd = 1'b0;
	o_wr = 1'b0;
	o_addr = 16'h0000;
end
// gap idles first, so slow masters are covered too
task automatic xfer(input logic w, input logic [15:0] a, input int gap,
	output logic [15:0] d, output logic h, output logic ok);
	int n;
	ok = 1'b0;
	d = 16'h0000;
	h = 1'b0;
	repeat (gap + 1) @(posedge i_clk);
	o_rd <= !w;
	o_wr <= w;
	o_addr <= a;
	for (n = 0; n < 8 && !ok; n++)
	begin
		@(posedge i_clk);
		if (i_ack === 1'b1)
		begin
			ok = 1'b1;
			d = i_rdata;
			h = i_hit;
		end
	end
	o_rd <= 1'b0;
	o_wr <= 1'b0;
	// released address no longer shows the old value
	o_addr <= ~a;
endtask
endmodule // dmsr_master_model
`default_nettype wire

// [verification/drive_monitor_status_registers_tb.sv]
// self-checking bench for the drive monitor register bank
`timescale 1ns/1ps
`default_nettype none
module drive_monitor_status_registers_tb;
localparam int SMP = 2;
logic clk = 1'b0;
logic rst_n = 1'b0;
logic [6:0] term = 7'h00;
logic [1:0] cont = 2'b00;
dmsr_pkg::dmsr_drive_flags_s flg = '0;
dmsr_pkg::dmsr_levels_s lvl = '0;
dmsr_pkg::dmsr_ident_s idn = '0;
logic [6:0] lerr = 7'h00;
logic frst = 1'b0;
logic rd, wr, ack, hit;
logic [15:0] addr, rdata;
int err_count = 0;
int n_compared = 0;
int i;
int pos [12] = '{0, 1, 2, 3, 6, 7, 9, 10, 11, 12, 13, 14};
always #12.5 clk = ~clk;
dmsr_monitor_regs #(.SAMPLE_CYCLES(SMP)) DUT (.i_clk(clk), .i_reset_n(rst_n),
	.i_input_terminals(term), .i_output_contacts(cont), .i_flags(flg), .i_levels(lvl),
	.i_ident(idn), .i_link_err(lerr), .i_fault_reset(frst), .i_rd(rd), .i_wr(wr),
	.i_addr(addr), .o_ack(ack), .o_hit(hit), .o_rdata(rdata));
dmsr_master_model M (.i_clk(clk), .o_rd(rd), .o_wr(wr), .o_addr(addr), .i_ack(ack),
	.i_hit(hit), .i_rdata(rdata));
////////////////////////////////////////////////////////////////////////////////
task automatic complete_run();
	$display("compared %0d mismatches %0d", n_compared, err_count);
	if (err_count == 0 && n_compared > 0)
		$display("*** PASS ***");
	else
		$display("*** FAIL ***");
	$finish;
endtask
task automatic chk(input logic w, input logic [15:0] a, input logic [15:0] e, input logic eh);
	logic [15:0] d;
	logic h;
	logic ok;
	M.xfer(w, a, n_compared % 3, d, h, ok);
	n_compared++;
	if (ok !== 1'b1)
	begin
		err_count++;
		$display("MISMATCH t=%0t no answer at %h", $time, a);
		complete_run();
	end
	else if ({h, d} !== {eh, e})
	begin
		err_count++;
		$display("MISMATCH t=%0t got %h exp %h", $time, {h, d}, {eh, e});
	end
endtask
// snapshots refresh once per tick; wait past two of them
task automatic tick();
	repeat (2 * SMP + 2) @(posedge clk);
endtask
////////////////////////////////////////////////////////////////////////////////
initial
begin
	repeat (6) @(posedge clk);
	rst_n <= 1'b1;
	@(posedge clk);
	term <= 7'h55;
	cont <= 2'b10;
	lvl <= {16'h1234, 16'h03e8, 16'hfc18, 16'h0190, 16'h0005, 16'h0003};
	idn <= {16'h0a01, 16'h0b02, 16'h0c03, 16'h0d04};
	tick();
	chk(0, 16'h003b, 16'h0a01, 1);
	chk(0, 16'h003c, 16'h0b02, 1);
	chk(0, 16'h003e, 16'h0c03, 1);
	chk(0, 16'h003f, 16'h0d04, 1);
	chk(0, 16'h002b, 16'h0055, 1);
	chk(0, 16'h002d, 16'h0002, 1);
	chk(0, 16'h0031, 16'h1234, 1);
	chk(0, 16'h0038, 16'h03e8, 1);
	chk(0, 16'h0039, 16'hfc18, 1);
	chk(0, 16'h003a, 16'h0190, 1);
	$display("levels test done");
	for (i = 0; i < 12; i++)
	begin
		@(posedge clk);
		flg <= 12'h800 >> i;
		tick();
		chk(0, 16'h002c, 16'h0020 | (16'h0001 << pos[i]), 1);
	end
	@(posedge clk);
	flg <= '0;
	lvl.out_freq <= 16'h0003;
	tick();
	chk(0, 16'h002c, 16'h0030, 1);
	@(posedge clk);
	lvl.out_freq <= 16'h0002;
	tick();
	chk(0, 16'h002c, 16'h0010, 1);
	$display("status test done");
	@(posedge clk);
	lerr <= 7'h7f;
	flg.run <= 1'b1;
	@(posedge clk);
	lerr <= 7'h00;
	tick();
	chk(0, 16'h003d, 16'h007b, 1);
	chk(0, 16'h002c, 16'hc011, 1);
	@(posedge clk);
	frst <= 1'b1;
	@(posedge clk);
	frst <= 1'b0;
	tick();
	chk(0, 16'h003d, 16'h0000, 1);
	chk(0, 16'h002c, 16'h0011, 1);
	// an event in the clear cycle must survive the clear
	@(posedge clk);
	lerr <= 7'h01;
	frst <= 1'b1;
	@(posedge clk);
	lerr <= 7'h00;
	frst <= 1'b0;
	tick();
	chk(0, 16'h003d, 16'h0001, 1);
	$display("link error test done");
	chk(1, 16'h002b, 16'h0000, 1);
	chk(0, 16'h002b, 16'h0055, 1);
	chk(0, 16'h0030, 16'h0000, 1);
	chk(0, 16'h0040, 16'h0000, 0);
	$display("access test done");
	complete_run();
end
endmodule // drive_monitor_status_registers_tb
`default_nettype wire
